//--- common/coa_map.svh
// register offsets, field positions, constants and reset values of the operand addressing block
`ifndef COA_MAP_SVH
`define COA_MAP_SVH

// ****************************************
// apb register byte offsets
// ****************************************
`define COA_OFF_CTRL 12'h000
`define COA_OFF_STATUS 12'h004
`define COA_OFF_PC 12'h008
`define COA_OFF_SR 12'h00C
`define COA_OFF_REGSEL 12'h010
`define COA_OFF_REGDAT 12'h014

// ****************************************
// register fields
// ****************************************
`define COA_CTRL_GO 0
`define COA_STAT_BUSY 0
`define COA_STAT_DONE 1
`define COA_SR_Z_BIT 1
`define COA_SR_N_BIT 2

// ****************************************
// instruction word fields
// ****************************************
`define COA_IR_SRC 11:8
`define COA_IR_AD 7
`define COA_IR_BW 6
`define COA_IR_AS 5:4
`define COA_IR_DST 3:0

// ****************************************
// register numbers and source modes
// ****************************************
`define COA_REG_PC 4'h0
`define COA_REG_SR 4'h2
`define COA_REG_CG2 4'h3
`define COA_AS_REG 2'h0
`define COA_AS_IDX 2'h1
`define COA_AS_IND 2'h2
`define COA_AS_INC 2'h3

// ****************************************
// generated constants and steps
// ****************************************
`define COA_CG1_FOUR 16'h0004
`define COA_CG1_EIGHT 16'h0008
`define COA_CG2_ZERO 16'h0000
`define COA_CG2_ONE 16'h0001
`define COA_CG2_TWO 16'h0002
`define COA_CG2_ONES 16'hFFFF
`define COA_WORD_STEP 16'h0002
`define COA_BYTE_STEP 16'h0001
`define COA_ZERO16 16'h0000
`define COA_ZERO32 32'h0000_0000
`define COA_PC_RST 16'h0000
`define COA_SR_RST 16'h0000

`endif

//--- common/coa_pkg.sv
// types shared by the operand addressing block
package coa_pkg;

	// ****************************************
	// sequencer states
	// ****************************************
	typedef enum logic [3:0] {
		COA_IDLE = 4'b0000,
		COA_FETCH = 4'b0001,
		COA_SREG = 4'b0010,
		COA_SDEC = 4'b0011,
		COA_SEXT = 4'b0100,
		COA_SRD = 4'b0101,
		COA_DREG = 4'b0110,
		COA_DDEC = 4'b0111,
		COA_DEXT = 4'b1000,
		COA_DWR = 4'b1001,
		COA_DONE = 4'b1010
	} coa_state_t;

	// ****************************************
	// memory bus request
	// ****************************************
	typedef struct packed {
		logic req;
		logic we;
		logic byte_acc;
		logic [15:0] addr;
		logic [15:0] wdata;
	} coa_mem_req_t;

endpackage

//--- hw/coa_regfile.sv
// register file of the cpu with registered read data
`timescale 1ns/1ps
module coa_regfile
#(
	parameter int DEPTH = 16,
	parameter int WIDTH = 16
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic [WIDTH-1:0] rdata,
	input wire logic we,
	input wire logic [$clog2(DEPTH)-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata
);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [WIDTH-1:0] rdata_ff;

	// ****************************************
	// storage, one write port per entry
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : g_word
			always_ff @(posedge clk)
			begin
				if (we && (waddr == ($clog2(DEPTH))'(gi)))
					mem_ff[gi] <= wdata;
			end
		end
	endgenerate

	// read data come one cycle after the address
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rdata_ff <= '0;
		else
			rdata_ff <= mem_ff[raddr];
	end

	assign rdata = rdata_ff;
endmodule

//--- hw/coa_operand_addr.sv
// operand addressing and constant generation sequencer with apb control
// How it works
// RULE1: second generator mode 00 supplies zero
// RULE2: generators give 4, 8, 0, 1, 2, all-ones
// RULE3: general registers usable as byte or word
// RULE4: seven source, four destination modes decoded
// RULE5: mode zero uses register content, no memory
// RULE6: indexed address is register plus extension word
// RULE7: symbolic address is program counter plus offset
// RULE8: absolute uses status register base of zero
// RULE9: source mode 10 reads through register pointer
// RULE10: autoincrement steps register by one or two
// RULE11: immediate read through program counter, stepping it
// RULE12: any source mode pairs with any destination
// RULE13: byte register writes clear upper byte, flags
// RULE14: base registers unchanged, counter passes extensions
// RULE15: symbolic offset added as signed difference
// RULE16: extension words fetched in order after opcode
// RULE17: program counter even, steps two per word
// RULE18: relative base is extension word address
// RULE19: status register mode zero is plain operand
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`include "coa_map.svh"
module coa_operand_addr
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output coa_pkg::coa_mem_req_t mem_req,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata
);
	import coa_pkg::*;

	coa_state_t state_ff;
	coa_state_t nxt_state;
	coa_mem_req_t mem_ff;
	logic [15:0] ir_ff;
	logic [15:0] pc_ff;
	logic [15:0] sr_ff;
	logic [15:0] op_ff;
	logic [15:0] ea_ff;
	logic [15:0] base_ff;
	logic [3:0] regsel_ff;
	logic done_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic [3:0] rf_raddr;
	logic [3:0] rf_waddr;
	logic [15:0] rf_rdata;
	logic [15:0] rf_wdata;
	logic rf_we;
	logic [3:0] src;
	logic [3:0] dst;
	logic [1:0] as_mode;
	logic ad_mode;
	logic bw;
	logic busy;
	logic got;
	logic src_const;
	logic [15:0] sv;
	logic [15:0] dv;
	logic [15:0] res;
	logic [15:0] step_size;
	logic apb_access;
	logic apb_fire;
	logic apb_err;
	logic apb_ok_wr;
	logic go;

	// ****************************************
	// decoding helpers
	// ****************************************
	function automatic logic is_const(input logic [3:0] idx, input logic [1:0] am);
		is_const = (idx == `COA_REG_CG2) || ((idx == `COA_REG_SR) && am[1]);
	endfunction

	function automatic logic [15:0] cg_value(input logic [3:0] idx, input logic [1:0] am);
		cg_value = `COA_CG2_ZERO;
		if (idx == `COA_REG_SR)
			cg_value = (am == `COA_AS_INC) ? `COA_CG1_EIGHT : `COA_CG1_FOUR;
		else
		begin
			case (am)
				`COA_AS_REG: cg_value = `COA_CG2_ZERO;
				`COA_AS_IDX: cg_value = `COA_CG2_ONE;
				`COA_AS_IND: cg_value = `COA_CG2_TWO;
				default: cg_value = `COA_CG2_ONES;
			endcase
		end
	endfunction

	// program counter and status register live outside the register file
	function automatic logic [15:0] reg_value(input logic [3:0] idx, input logic [15:0] rfd,
		input logic [15:0] pc, input logic [15:0] sr);
		if (idx == `COA_REG_PC)
			reg_value = pc;
		else if (idx == `COA_REG_SR)
			reg_value = sr;
		else
			reg_value = rfd;
	endfunction

	function automatic logic is_general(input logic [3:0] idx);
		is_general = (idx != `COA_REG_PC) && (idx != `COA_REG_SR) && (idx != `COA_REG_CG2);
	endfunction

	assign src = ir_ff[`COA_IR_SRC];
	assign dst = ir_ff[`COA_IR_DST];
	assign as_mode = ir_ff[`COA_IR_AS];
	assign ad_mode = ir_ff[`COA_IR_AD];
	assign bw = ir_ff[`COA_IR_BW];
	assign busy = (state_ff != COA_IDLE);
	assign got = mem_ff.req && mem_ack;
	assign src_const = is_const(src, as_mode);
	assign sv = reg_value(src, rf_rdata, pc_ff, sr_ff);
	assign dv = reg_value(dst, rf_rdata, pc_ff, sr_ff);
	// RULE13: byte result keeps upper byte clear
	assign res = bw ? {8'h00, op_ff[7:0]} : op_ff;
	// RULE10: step of one for bytes, two for words
	assign step_size = bw ? `COA_BYTE_STEP : `COA_WORD_STEP;

	// ****************************************
	// apb slave
	// ****************************************
	assign apb_access = psel && penable;
	assign apb_fire = apb_access && pready_ff;
	assign apb_ok_wr = apb_fire && pwrite && !pslverr_ff;
	assign go = apb_ok_wr && (paddr == `COA_OFF_CTRL) && pwdata[`COA_CTRL_GO];

	// unmapped, or writing control, counter or status, or any register data access, while an instruction runs
	always_comb
	begin
		case (paddr)
			`COA_OFF_CTRL: apb_err = busy && pwrite;
			`COA_OFF_STATUS: apb_err = 1'b0;
			`COA_OFF_PC: apb_err = busy && pwrite;
			`COA_OFF_SR: apb_err = busy && pwrite;
			`COA_OFF_REGSEL: apb_err = 1'b0;
			`COA_OFF_REGDAT: apb_err = busy;
			default: apb_err = 1'b1;
		endcase
	end

	// every access answers in its second access cycle
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= `COA_ZERO32;
		end
		else
		begin
			pready_ff <= apb_access && !pready_ff;
			pslverr_ff <= apb_access && !pready_ff && apb_err;
			prdata_ff <= `COA_ZERO32;
			if (apb_access && !pready_ff && !pwrite && !apb_err)
			begin
				case (paddr)
					`COA_OFF_STATUS: prdata_ff <= {30'h0000_0000, done_ff, busy};
					`COA_OFF_PC: prdata_ff <= {16'h0000, pc_ff};
					`COA_OFF_SR: prdata_ff <= {16'h0000, sr_ff};
					`COA_OFF_REGSEL: prdata_ff <= {28'h000_0000, regsel_ff};
					`COA_OFF_REGDAT: prdata_ff <= {16'h0000, rf_rdata};
					default: prdata_ff <= `COA_ZERO32;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			regsel_ff <= 4'h0;
		else if (apb_ok_wr && (paddr == `COA_OFF_REGSEL))
			regsel_ff <= pwdata[3:0];
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			done_ff <= 1'b0;
		else if (go)
			done_ff <= 1'b0;
		else if (state_ff == COA_DONE)
			done_ff <= 1'b1;
	end

	// ****************************************
	// register file ports
	// ****************************************
	always_comb
	begin
		case (state_ff)
			COA_SREG: rf_raddr = src;
			COA_DREG: rf_raddr = dst;
			default: rf_raddr = regsel_ff;
		endcase
	end

	always_comb
	begin
		rf_we = 1'b0;
		rf_waddr = regsel_ff;
		rf_wdata = pwdata[15:0];
		// RULE10: autoincrement writes the pointer back
		if ((state_ff == COA_SDEC) && (as_mode == `COA_AS_INC) && is_general(src))
		begin
			rf_we = 1'b1;
			rf_waddr = src;
			rf_wdata = sv + step_size;
		end
		// RULE3: general register takes byte or word result
		else if ((state_ff == COA_DDEC) && !ad_mode && is_general(dst))
		begin
			rf_we = 1'b1;
			rf_waddr = dst;
			rf_wdata = res;
		end
		else if (!busy && apb_ok_wr && (paddr == `COA_OFF_REGDAT))
			rf_we = 1'b1;
	end

	coa_regfile #(.DEPTH(16), .WIDTH(16)) u_regs
	(
		.clk(clk),
		.rstn(rstn),
		.raddr(rf_raddr),
		.rdata(rf_rdata),
		.we(rf_we),
		.waddr(rf_waddr),
		.wdata(rf_wdata)
	);

	// ****************************************
	// sequencer
	// ****************************************
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			COA_IDLE: if (go) nxt_state = COA_FETCH;
			COA_FETCH: if (got) nxt_state = COA_SREG;
			COA_SREG: nxt_state = COA_SDEC;
			// RULE4: source mode decode
			COA_SDEC:
			begin
				if (src_const || (as_mode == `COA_AS_REG))
					nxt_state = COA_DREG;
				else if (as_mode == `COA_AS_IDX)
					nxt_state = COA_SEXT;
				else
					nxt_state = COA_SRD;
			end
			COA_SEXT: if (got) nxt_state = COA_SRD;
			COA_SRD: if (got) nxt_state = COA_DREG;
			// RULE12: destination decode is independent of source mode
			COA_DREG: nxt_state = COA_DDEC;
			COA_DDEC: nxt_state = ad_mode ? COA_DEXT : COA_DONE;
			COA_DEXT: if (got) nxt_state = COA_DWR;
			COA_DWR: if (got) nxt_state = COA_DONE;
			COA_DONE: nxt_state = COA_IDLE;
			default: nxt_state = COA_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			state_ff <= COA_IDLE;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ir_ff <= `COA_ZERO16;
		else if ((state_ff == COA_FETCH) && got)
			ir_ff <= mem_rdata;
	end

	// ****************************************
	// program counter
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pc_ff <= `COA_PC_RST;
		else if (!busy && apb_ok_wr && (paddr == `COA_OFF_PC))
			pc_ff <= {pwdata[15:1], 1'b0};
		// RULE16: opcode then extension words, in order
		else if (got && ((state_ff == COA_FETCH) || (state_ff == COA_SEXT)
			|| (state_ff == COA_DEXT)))
			pc_ff <= pc_ff + `COA_WORD_STEP;
		// RULE11: immediate steps the counter past its word
		else if ((state_ff == COA_SDEC) && (as_mode == `COA_AS_INC) && (src == `COA_REG_PC))
			pc_ff <= pc_ff + `COA_WORD_STEP;
		// RULE17: a written counter stays even
		else if ((state_ff == COA_DDEC) && !ad_mode && (dst == `COA_REG_PC))
			pc_ff <= {res[15:1], 1'b0};
	end

	// ****************************************
	// status word
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			sr_ff <= `COA_SR_RST;
		else if (!busy && apb_ok_wr && (paddr == `COA_OFF_SR))
			sr_ff <= pwdata[15:0];
		else if ((state_ff == COA_DDEC) && !ad_mode && (dst == `COA_REG_SR))
			sr_ff <= res;
		// RULE13: flags follow the byte or word result
		else if (((state_ff == COA_DDEC) && !ad_mode) || ((state_ff == COA_DWR) && got))
		begin
			sr_ff[`COA_SR_Z_BIT] <= (res == `COA_ZERO16);
			sr_ff[`COA_SR_N_BIT] <= bw ? res[7] : res[15];
		end
	end

	// ****************************************
	// operand and address path
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			op_ff <= `COA_ZERO16;
			ea_ff <= `COA_ZERO16;
			base_ff <= `COA_ZERO16;
		end
		else
		begin
			case (state_ff)
				COA_SDEC:
				begin
					// RULE1: second generator gives the cleared value
					// RULE2: constant without a code word
					if (src_const)
						op_ff <= cg_value(src, as_mode);
					// RULE5: register content, no memory cycle
					// RULE19: status word in mode zero is a normal operand
					else if (as_mode == `COA_AS_REG)
						op_ff <= bw ? {8'h00, sv[7:0]} : sv;
					// RULE8: absolute mode base reads as zero
					// RULE18: counter base equals extension word address
					else if (as_mode == `COA_AS_IDX)
						base_ff <= (src == `COA_REG_SR) ? `COA_ZERO16 : sv;
					// RULE9: register content points at the operand
					else
						ea_ff <= sv;
				end
				// RULE6: register plus extension offset
				// RULE7: counter plus offset for symbolic operands
				// RULE15: offset wraps as a signed difference
				// RULE14: base register itself is never written
				COA_SEXT: if (got) ea_ff <= base_ff + mem_rdata;
				COA_SRD: if (got) op_ff <= bw ? {8'h00, mem_rdata[7:0]} : mem_rdata;
				COA_DDEC: base_ff <= (dst == `COA_REG_SR) ? `COA_ZERO16 : dv;
				COA_DEXT: if (got) ea_ff <= base_ff + mem_rdata;
				default: ea_ff <= ea_ff;
			endcase
		end
	end

	// ****************************************
	// memory request, held until acknowledged
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			mem_ff <= '0;
		else
		begin
			mem_ff.req <= ((state_ff == COA_FETCH) || (state_ff == COA_SEXT)
				|| (state_ff == COA_SRD) || (state_ff == COA_DEXT)
				|| (state_ff == COA_DWR)) && !got;
			mem_ff.we <= (state_ff == COA_DWR);
			mem_ff.byte_acc <= bw && ((state_ff == COA_SRD) || (state_ff == COA_DWR));
			mem_ff.addr <= ((state_ff == COA_SRD) || (state_ff == COA_DWR)) ? ea_ff : pc_ff;
			mem_ff.wdata <= res;
		end
	end

	assign mem_req = mem_ff;
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_pc_even_step: assert property (pc_ff[0] == 1'b0) // RULE17
		else $error("program counter is odd");
	a_cg2_zero: assert property ((state_ff == COA_SDEC) && (src == `COA_REG_CG2)
		&& (as_mode == `COA_AS_REG) |=> (op_ff == `COA_CG2_ZERO) && (state_ff == COA_DREG)) // RULE1
		else $error("second generator mode zero did not give zero");
	a_cg1_consts: assert property ((state_ff == COA_SDEC) && (src == `COA_REG_SR) && as_mode[1]
		|=> op_ff == (as_mode[0] ? `COA_CG1_EIGHT : `COA_CG1_FOUR)) // RULE2
		else $error("first generator constant wrong");
	a_reg_no_mem: assert property ((state_ff == COA_SDEC) && (as_mode == `COA_AS_REG)
		&& !ad_mode |=> !mem_ff.req [*3]) // RULE5
		else $error("register operand caused a memory cycle");
	a_imm_pc_step: assert property ((state_ff == COA_SDEC) && (src == `COA_REG_PC)
		&& (as_mode == `COA_AS_INC) |=> (pc_ff == $past(pc_ff) + `COA_WORD_STEP)
		&& (ea_ff == $past(pc_ff))) // RULE11
		else $error("immediate did not read at counter and step it");
	a_ext_address: assert property ((state_ff == COA_SEXT) && got
		|=> (ea_ff == $past(base_ff) + $past(mem_rdata))
		&& (pc_ff == $past(pc_ff) + `COA_WORD_STEP)) // RULE6
		else $error("indexed address or counter step wrong");
	a_abs_base: assert property ((state_ff == COA_SDEC) && (src == `COA_REG_SR)
		&& (as_mode == `COA_AS_IDX) |=> base_ff == `COA_ZERO16 ##1 state_ff == COA_SEXT) // RULE8
		else $error("absolute base not zero");
	a_idx_base_kept: assert property ((state_ff == COA_SEXT) || (state_ff == COA_DEXT)
		|-> !rf_we) // RULE14
		else $error("base register written during extension fetch");
	a_byte_clear: assert property ((state_ff == COA_DDEC) && !ad_mode && bw && rf_we
		|-> rf_wdata[15:8] == 8'h00) // RULE13
		else $error("byte write left upper byte set");
	a_autoinc_step: assert property ((state_ff == COA_SDEC) && (as_mode == `COA_AS_INC)
		&& is_general(src) |-> rf_we && (rf_waddr == src)
		&& (rf_wdata - sv == (bw ? `COA_BYTE_STEP : `COA_WORD_STEP))) // RULE10
		else $error("autoincrement step wrong");
	a_req_hold: assert property (mem_ff.req && !mem_ack |=> mem_ff.req && $stable(mem_ff.addr)
		&& $stable(mem_ff.we)) // RULE16
		else $error("memory request dropped before acknowledge");
endmodule

//--- bench/coa_mem_model.sv
// program and data memory model on the far side of the operand addressing block
`timescale 1ns/1ps
module coa_mem_model
(
	input wire logic clk,
	input wire logic rstn,
	input wire coa_pkg::coa_mem_req_t mem_req,
	output logic mem_ack,
	output logic [15:0] mem_rdata
);
	import coa_pkg::*;
	logic [15:0] mem [0:32767];
	logic [15:0] log_q [$];
	int wait_n = 0;
	int cnt;
	logic [15:0] w;
	// ****
	// access engine
	// ****
	// read data toggles whenever it is not valid, so a late sample never matches by luck
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mem_ack <= 1'b0;
			mem_rdata <= 16'h5A5A;
			cnt = 0;
		end
		else if (mem_ack || !mem_req.req)
		begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
		else if (cnt < wait_n)
		begin
			cnt = cnt + 1;
			mem_rdata <= ~mem_rdata;
		end
		else
		begin
			cnt = 0;
			log_q.push_back(mem_req.addr);
			w = mem[mem_req.addr[15:1]];
			if (mem_req.we && mem_req.byte_acc && mem_req.addr[0])
				w[15:8] = mem_req.wdata[7:0];
			else if (mem_req.we && mem_req.byte_acc)
				w[7:0] = mem_req.wdata[7:0];
			else if (mem_req.we)
				w = mem_req.wdata;
			else if (mem_req.byte_acc && mem_req.addr[0])
				w = {~w[15:8], w[15:8]};
			else if (mem_req.byte_acc)
				w = {~w[7:0], w[7:0]};
			if (mem_req.we)
				mem[mem_req.addr[15:1]] = w;
			mem_rdata <= w;
			mem_ack <= 1'b1;
		end
	end
endmodule

//--- bench/testbench.sv
// self-checking testbench of the operand addressing block
`timescale 1ns/1ps
`include "coa_map.svh"
module testbench;
	import coa_pkg::*;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, mem_ack, er, bw;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] mem_rdata, p, a, b, x, y, v, t;
	logic [3:0] d;
	coa_mem_req_t mem_req;
	int n_fail = 0;
	int n_compared = 0;
	int seed = 80755;
	int k, i;
	logic [15:0] ctab [6] = '{16'h0000, 16'h0001, 16'h0002, 16'hFFFF, 16'h0004, 16'h0008};
	logic [5:0] stab [6] = '{6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h0A, 6'h0B};
	coa_operand_addr coa_operand_addr_inst (.clk(clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));
	coa_mem_model coa_mem_model_inst (.clk(clk), .rstn(rstn), .mem_req(mem_req),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ****
	// helpers
	// ****
	task automatic close_out();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] dat);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= dat;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			n_fail++;
			close_out();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic setr(input logic [3:0] r, input logic [15:0] val);
		apb(1'b1, `COA_OFF_REGSEL, {28'h0, r});
		apb(1'b1, `COA_OFF_REGDAT, {16'h0, val});
	endtask
	task automatic getr(input logic [3:0] r);
		apb(1'b1, `COA_OFF_REGSEL, {28'h0, r});
		apb(1'b0, `COA_OFF_REGDAT, 32'h0);
	endtask
	function automatic logic [15:0] ins(input logic [3:0] s, input logic ad, input logic b8,
		input logic [1:0] as, input logic [3:0] dr);
		return {4'h4, s, ad, b8, as, dr};
	endfunction
	function automatic logic [15:0] rnd();
		return 16'h4000 | (16'($random(seed)) & 16'h3FFE);
	endfunction
	// loads the code words at p, starts one instruction and waits for it
	task automatic run(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2,
		input int n);
		coa_mem_model_inst.mem[p[15:1]] = w0;
		coa_mem_model_inst.mem[p[15:1] + 15'h0001] = w1;
		coa_mem_model_inst.mem[p[15:1] + 15'h0002] = w2;
		coa_mem_model_inst.log_q.delete();
		coa_mem_model_inst.wait_n = $random(seed) & 3;
		apb(1'b1, `COA_OFF_PC, {16'h0, p});
		apb(1'b1, `COA_OFF_CTRL, 32'h0000_0001);
		k = 0;
		do
		begin
			apb(1'b0, `COA_OFF_STATUS, 32'h0);
			k++;
		end
		while (rd[`COA_STAT_DONE] !== 1'b1 && k < 200);
		chk(rd[`COA_STAT_DONE], 1'b1, "done");
		if (rd[`COA_STAT_DONE] !== 1'b1)
			close_out();
		apb(1'b0, `COA_OFF_PC, 32'h0);
		chk(rd, {16'h0, p + 16'(2 * n)}, "pc step");
	endtask
	// ****
	// scenarios
	// ****
	initial
	begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, 12'h0F0, 32'h0);
		chk(er, 1'b1, "unmapped");
		// indexed source to indexed destination
		p = 16'h0100;
		a = rnd();
		b = rnd();
		x = 16'($random(seed)) & 16'h00FE;
		y = 16'($random(seed)) & 16'h00FE;
		v = 16'($random(seed));
		coa_mem_model_inst.mem[(a + x) >> 1] = v;
		setr(5, a);
		setr(6, b);
		run(ins(5, 1'b1, 1'b0, 2'h1, 6), x, y, 3);
		chk(coa_mem_model_inst.mem[(b + y) >> 1], v, "idx move");
		chk(coa_mem_model_inst.log_q.size(), 5, "access count");
		chk(coa_mem_model_inst.log_q[1], p + 2, "src ext");
		chk(coa_mem_model_inst.log_q[2], a + x, "src ea");
		chk(coa_mem_model_inst.log_q[3], p + 4, "dst ext");
		chk(coa_mem_model_inst.log_q[4], b + y, "dst ea");
		getr(5);
		chk(rd, a, "base r5");
		getr(6);
		chk(rd, b, "base r6");
		$display("test indexed done");
		// generated constants, no extra code word or memory read
		for (i = 0; i < 6; i++)
		begin
			setr(7, 16'h1357);
			run(ins(stab[i][5:2], 1'b0, 1'b0, stab[i][1:0], 7), 16'h0, 16'h0, 1);
			chk(coa_mem_model_inst.log_q.size(), 1, "cg fetch");
			getr(7);
			chk(rd, ctab[i], "constant");
		end
		$display("test constants done");
		// symbolic from a high code address, offset wraps round
		p = 16'hFF12;
		t = rnd();
		v = 16'($random(seed));
		coa_mem_model_inst.mem[t >> 1] = v;
		run(ins(0, 1'b0, 1'b0, 2'h1, 8), t - (p + 16'h0002), 16'h0, 2);
		chk(coa_mem_model_inst.log_q[1], p + 2, "sym ext");
		chk(coa_mem_model_inst.log_q[2], t, "sym ea");
		getr(8);
		chk(rd, v, "sym data");
		// absolute, base must read as zero although flags are set
		apb(1'b1, `COA_OFF_SR, 32'h0000_0006);
		p = 16'h0200;
		run(ins(2, 1'b0, 1'b0, 2'h1, 9), t, 16'h0, 2);
		chk(coa_mem_model_inst.log_q[2], t, "abs ea");
		getr(9);
		chk(rd, v, "abs data");
		$display("test symbolic absolute done");
		// indirect, word and byte autoincrement, immediate
		setr(5, t);
		run(ins(5, 1'b0, 1'b0, 2'h2, 10), 16'h0, 16'h0, 1);
		getr(10);
		chk(rd, v, "indirect");
		getr(5);
		chk(rd, t, "ptr kept");
		setr(6, t);
		run(ins(6, 1'b0, 1'b0, 2'h3, 11), 16'h0, 16'h0, 1);
		getr(6);
		chk(rd, t + 16'h0002, "inc word");
		setr(6, t);
		run(ins(6, 1'b0, 1'b1, 2'h3, 11), 16'h0, 16'h0, 1);
		getr(6);
		chk(rd, t + 16'h0001, "inc byte");
		getr(11);
		chk(rd, {24'h0, v[7:0]}, "byte load");
		apb(1'b0, `COA_OFF_SR, 32'h0);
		chk(rd[`COA_SR_N_BIT], v[7], "byte n");
		chk(rd[`COA_SR_Z_BIT], v[7:0] == 8'h00, "byte z");
		v = 16'($random(seed));
		run(ins(0, 1'b0, 1'b0, 2'h3, 12), v, 16'h0, 2);
		chk(coa_mem_model_inst.log_q[1], p + 2, "imm fetch");
		getr(12);
		chk(rd, v, "immediate");
		// byte register to an odd absolute destination, only the high lane is written
		setr(5, v);
		x = rnd() | 16'h0001;
		coa_mem_model_inst.mem[x >> 1] = 16'h0000;
		run(ins(5, 1'b1, 1'b1, 2'h0, 2), x, 16'h0, 2);
		chk(coa_mem_model_inst.log_q[2], x, "abs dst ea");
		chk(coa_mem_model_inst.mem[x >> 1], {v[7:0], 8'h00}, "abs byte write");
		$display("test pointer modes done");
		// status register in register mode is a plain operand
		apb(1'b1, `COA_OFF_SR, 32'h0000_0006);
		run(ins(2, 1'b0, 1'b0, 2'h0, 13), 16'h0, 16'h0, 1);
		getr(13);
		chk(rd, 32'h0000_0006, "sr operand");
		// register mode across general registers 4 to 15, random width
		for (i = 4; i < 16; i++)
		begin
			d = (i == 15) ? 4'h4 : 4'(i + 1);
			bw = 1'($random(seed));
			v = 16'($random(seed));
			setr(4'(i), v);
			run(ins(4'(i), 1'b0, bw, 2'h0, d), 16'h0, 16'h0, 1);
			chk(coa_mem_model_inst.log_q.size(), 1, "reg no mem");
			getr(d);
			chk(rd, bw ? {24'h0, v[7:0]} : {16'h0, v}, "reg move");
		end
		$display("test register mode done");
		close_out();
	end
	initial
	begin
		repeat (90000) @(posedge clk);
		n_fail++;
		close_out();
	end
endmodule
